// ### dv/lpcg_top_assertions.sv
// Checker for the clock gating block, watching its top-level ports.
// Assumes one clock and a synchronous active-low reset.
`default_nettype none
module lpcg_top_assertions
    import lpcg_pkg::*;
(
    // Clock and reset.
    input wire logic clk,
    input wire logic rstn,
    // Register port.
    input wire logic [LPCG_AW-1:0] reg_addr,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [LPCG_DW-1:0] reg_rdata,
    input wire logic reg_err,
    // Mode and unit side.
    input wire logic [1:0] power_mode,
    input wire logic [LPCG_NUNITS-1:0] unit_access,
    input wire logic [LPCG_NUNITS-1:0] unit_clk_en,
    input wire logic unit_bus_fault
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);
    // Offset decode; the reserved-bit check covers only the three gate registers.
    wire logic gate_hit = reg_addr inside {12'h100, 12'h110, 12'h120};
    wire logic mapped = gate_hit || reg_addr inside {12'h060, 12'h130};
    wire logic gated = |(unit_access & ~unit_clk_en);
    a_gated_fault: assert property (gated |=> unit_bus_fault)
        else $error("missing unit fault");
    a_open_no_fault: assert property (!gated |=> !unit_bus_fault)
        else $error("spurious unit fault");
    a_reset_enables: assert property (
        $past(!rstn) |-> unit_clk_en == 3'h2) else $error("bad reset enables");
    a_reserved_zero: assert property (reg_rd && gate_hit |=>
        (reg_rdata & ~LPCG_GATE_MASK) == 32'h0000_0000)
        else $error("reserved bits set");
    a_unmapped_err: assert property (reg_rd && !mapped |=>
        reg_err && reg_rdata == 32'h0000_0000) else $error("no error");
    a_mapped_no_err: assert property ((reg_rd || reg_wr) && mapped |=>
        !reg_err) else $error("error on mapped");
    a_rdata_idle: assert property (!reg_rd |=> reg_rdata == 32'h0000_0000)
        else $error("read data outside slot");
    a_enable_cause: assert property ($changed(unit_clk_en) &&
        $past(rstn) |-> $past(reg_wr) || $changed(power_mode))
        else $error("enable changed alone");
    // Main scenarios reached.
    c_fault: cover property (unit_bus_fault);
    c_err: cover property (reg_err);
    c_deep: cover property (power_mode == 2'h2 && unit_clk_en == 3'h2);
endmodule // lpcg_top_assertions
`default_nettype wire

// ### dv/lpcg_top_tb.sv
// Testbench for the clock gating block: registers, modes, unit faults.
// Assumes the package and design are compiled first; binds the checker.
`default_nettype none
module lpcg_top_tb
    import lpcg_pkg::*;
();
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0, rstn = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
    logic [11:0] reg_addr = 12'h000;
    logic [31:0] reg_wdata = 32'h0000_0000, reg_rdata;
    logic [1:0] power_mode = 2'h0;
    logic [2:0] unit_access = 3'h0, unit_clk_en;
    logic reg_err, unit_bus_fault;
    int n_errors = 0, n_checks = 0;
    lpcg_top uut (.clk, .rstn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
        .reg_rdata, .reg_err, .power_mode, .unit_access, .unit_clk_en,
        .unit_bus_fault);
    // Free-running 100 MHz clock.
    always #5 clk = ~clk;
    // Comparisons are case equality so an unknown never matches.
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask
    // Read data and error stand only in the cycle after the strobe.
    task automatic rd(input logic [11:0] a, input logic [31:0] e, logic r);
        @(posedge clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        @(negedge clk);
        chk(reg_rdata, e);
        chk(32'(reg_err), 32'(r));
    endtask
    task automatic md(input logic [1:0] m, input logic [2:0] e);
        @(posedge clk);
        power_mode <= m;
        @(negedge clk);
        chk(32'(unit_clk_en), 32'(e));
    endtask
    task automatic acc(input logic [2:0] u, input logic f);
        @(posedge clk);
        unit_access <= u;
        @(posedge clk);
        unit_access <= 3'h0;
        @(negedge clk);
        chk(32'(unit_bus_fault), 32'(f));
    endtask
    task automatic final_report;
        $display("checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    // Main sequence: reset values, masks, mode selection, faults, reset.
    initial begin
        repeat (3) @(posedge clk);
        rstn <= 1'b1;
        rd(12'h100, 32'h0000_0040, 1'b0);
        rd(12'h110, 32'h0000_0040, 1'b0);
        rd(12'h120, 32'h0000_0040, 1'b0);
        rd(12'h060, 32'h0000_0000, 1'b0);
        acc(3'h1, 1'b1);
        acc(3'h2, 1'b0);
        wr(12'h120, 32'hFFFF_FFFF);
        rd(12'h120, 32'h0010_0048, 1'b0);
        rd(12'h104, 32'h0000_0000, 1'b1);
        wr(12'h100, 32'h0000_0008);
        wr(12'h110, 32'h0010_0000);
        wr(12'h120, 32'h0000_0040);
        md(2'h1, 3'h1);
        md(2'h2, 3'h1);
        acc(3'h6, 1'b1);
        acc(3'h1, 1'b0);
        wr(12'h060, 32'h0800_0000);
        md(2'h0, 3'h1);
        md(2'h1, 3'h4);
        acc(3'h4, 1'b0);
        md(2'h2, 3'h2);
        rd(12'h130, 32'h0000_0006, 1'b0);
        md(2'h3, 3'h1);
        @(posedge clk);
        rstn <= 1'b0;
        @(posedge clk);
        rstn <= 1'b1;
        rd(12'h110, 32'h0000_0040, 1'b0);
        md(2'h1, 3'h2);
        final_report();
    end
endmodule // lpcg_top_tb
bind lpcg_top lpcg_top_assertions chk_i (.clk, .rstn, .reg_addr, .reg_wr,
    .reg_rd, .reg_rdata, .reg_err, .power_mode, .unit_access, .unit_clk_en,
    .unit_bus_fault);
`default_nettype wire

// ### src/lpcg_gate_reg.sv
// One gating register with masked writable bits and a fixed reset value.
// Assumes writes arrive as one-cycle strobes on the system clock.
`default_nettype none
module lpcg_gate_reg
    import lpcg_pkg::*;
#(
    parameter logic [31:0] MASK = LPCG_GATE_MASK,
    parameter logic [31:0] RESET_VAL = LPCG_GATE_RESET
) (
    // Clock and reset.
    input wire logic clk,
    input wire logic rstn,
    // Write side.
    input wire logic wr_en,
    input wire logic [31:0] wr_data,
    // Stored value.
    output logic [31:0] value
);
    logic [31:0] value_q;
    logic [31:0] value_d;

    // Unused bits never store, so they always read as zero.
    assign value_d = wr_en ? (wr_data & MASK) : value_q;
    assign value = value_q;

    // Reset value is the whole-register figure, keeper bit set.
    always_ff @(posedge clk) begin
        if (!rstn) begin
            value_q <= RESET_VAL;
        end else begin
            value_q <= value_d;
        end
    end
endmodule // lpcg_gate_reg
`default_nettype wire

// ### src/lpcg_pkg.sv
// Package for the low-power clock gating block: offsets, fields, resets.
// Assumes a 32-bit register port with byte offsets and one system clock.
`default_nettype none
package lpcg_pkg;
    localparam int unsigned LPCG_AW = 12;
    localparam int unsigned LPCG_DW = 32;
    localparam logic [11:0] LPCG_OFF_RUN_CFG = 12'h060;
    localparam logic [11:0] LPCG_OFF_RUN_GATE = 12'h100;
    localparam logic [11:0] LPCG_OFF_SLEEP_GATE = 12'h110;
    localparam logic [11:0] LPCG_OFF_DEEP_GATE = 12'h120;
    localparam logic [11:0] LPCG_OFF_MODE = 12'h130;
    localparam int unsigned LPCG_BIT_PWM = 20;
    localparam int unsigned LPCG_BIT_KEEPER = 6;
    localparam int unsigned LPCG_BIT_WDOG = 3;
    localparam int unsigned LPCG_BIT_ACG = 27;
    localparam int unsigned LPCG_NUNITS = 3;
    localparam logic [31:0] LPCG_GATE_MASK = 32'h0010_0048;
    localparam logic [31:0] LPCG_GATE_RESET = 32'h0000_0040;
    localparam logic [31:0] LPCG_CFG_MASK = 32'h0800_0000;
    localparam logic [31:0] LPCG_CFG_RESET = 32'h0000_0000;
    typedef enum logic [1:0] {
        LPCG_MODE_RUN,
        LPCG_MODE_SLEEP,
        LPCG_MODE_DEEP
    } lpcg_mode_e;
endpackage : lpcg_pkg
`default_nettype wire

// ### src/lpcg_top.sv
// Low-power clock gating control: run, sleep and deep-sleep gate registers,
// the auto-gating configuration bit, and per-unit clock enables.
// Assumes one system clock, a plain register port, a synchronous reset,
// and that the power mode comes from on-chip logic on the same clock.
//
// Behaviour
// - Set bit clocks unit, clear bit stops it.
// - Access to gated unit returns bus fault.
// - Gate bits reset cleared unless noted otherwise.
// - Run, sleep, deep registers govern their modes.
// - Sleep registers apply only with auto gating.
// - Bit 20 enables PWM clock, resets zero.
// - Bit 6 enables keeper unit clock.
// - Bit 3 enables watchdog clock, resets zero.
// - Unused bits read zero, ignore writes.
// - Sleep registers reset to 0x40 value.
// - Run gate register at 0x100, reset 0x40.
//
// The address-and-strobe port is this design's own decision.
`default_nettype none
module lpcg_top
    import lpcg_pkg::*;
(
    // Clock and reset.
    input wire logic clk,
    input wire logic rstn,
    // Register port.
    input wire logic [LPCG_AW-1:0] reg_addr,
    input wire logic [LPCG_DW-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [LPCG_DW-1:0] reg_rdata,
    output logic reg_err,
    // Power mode from the sleep controller: 0 run, 1 sleep, 2 deep.
    input wire logic [1:0] power_mode,
    // Unit access requests from the peripheral bus decoder.
    input wire logic [LPCG_NUNITS-1:0] unit_access,
    // Per-unit clock enables: bit 0 watchdog, 1 keeper, 2 PWM.
    output logic [LPCG_NUNITS-1:0] unit_clk_en,
    // Bus fault, high in the cycle after any cycle with a rejected unit access.
    output logic unit_bus_fault
);
    // Field positions of each unit in the gate registers.
    localparam int unsigned UNIT_BIT [LPCG_NUNITS] = '{
        LPCG_BIT_WDOG, LPCG_BIT_KEEPER, LPCG_BIT_PWM
    };

    logic [31:0] run_gate;
    logic [31:0] sleep_gate;
    logic [31:0] deep_gate;
    logic [31:0] cfg_q;
    logic [31:0] cfg_d;
    logic [31:0] rdata_q;
    logic [31:0] rdata_d;
    logic err_q;
    logic err_d;
    logic fault_q;
    logic fault_d;
    logic [31:0] active_gate;
    logic auto_gating;
    lpcg_mode_e mode;

    // Address decode for the register port.
    wire hit_cfg = (reg_addr == LPCG_OFF_RUN_CFG);
    wire hit_run = (reg_addr == LPCG_OFF_RUN_GATE);
    wire hit_sleep = (reg_addr == LPCG_OFF_SLEEP_GATE);
    wire hit_deep = (reg_addr == LPCG_OFF_DEEP_GATE);
    wire hit_mode = (reg_addr == LPCG_OFF_MODE);
    wire hit_any = hit_cfg | hit_run | hit_sleep | hit_deep | hit_mode;

    // The three gate registers share one implementation and reset value.
    lpcg_gate_reg #(
        .MASK(LPCG_GATE_MASK),
        .RESET_VAL(LPCG_GATE_RESET)
    ) u_run_gate (
        .clk(clk),
        .rstn(rstn),
        .wr_en(reg_wr & hit_run),
        .wr_data(reg_wdata),
        .value(run_gate)
    );

    lpcg_gate_reg #(
        .MASK(LPCG_GATE_MASK),
        .RESET_VAL(LPCG_GATE_RESET)
    ) u_sleep_gate (
        .clk(clk),
        .rstn(rstn),
        .wr_en(reg_wr & hit_sleep),
        .wr_data(reg_wdata),
        .value(sleep_gate)
    );

    lpcg_gate_reg #(
        .MASK(LPCG_GATE_MASK),
        .RESET_VAL(LPCG_GATE_RESET)
    ) u_deep_gate (
        .clk(clk),
        .rstn(rstn),
        .wr_en(reg_wr & hit_deep),
        .wr_data(reg_wdata),
        .value(deep_gate)
    );

    // Only the auto-gating bit of the run configuration lives here.
    assign cfg_d = (reg_wr & hit_cfg) ? (reg_wdata & LPCG_CFG_MASK) : cfg_q;
    assign auto_gating = cfg_q[LPCG_BIT_ACG];

    // Decode the mode input; the unused code behaves as run mode.
    always_comb begin
        case (power_mode)
            2'd1: mode = LPCG_MODE_SLEEP;
            2'd2: mode = LPCG_MODE_DEEP;
            default: mode = LPCG_MODE_RUN;
        endcase
    end

    // Select the governing register combinationally so enables follow the
    // mode in the same cycle; without auto gating sleep keeps run gating.
    always_comb begin
        case (mode)
            LPCG_MODE_SLEEP: begin
                active_gate = auto_gating ? sleep_gate : run_gate;
            end
            LPCG_MODE_DEEP: begin
                active_gate = auto_gating ? deep_gate : run_gate;
            end
            default: begin
                active_gate = run_gate;
            end
        endcase
    end

    // One enable per unit, taken from that unit's field.
    genvar gi;
    generate
        for (gi = 0; gi < LPCG_NUNITS; gi++) begin : g_unit
            assign unit_clk_en[gi] = active_gate[UNIT_BIT[gi]];
        end
    endgenerate

    // Any access to an unclocked unit faults instead of completing.
    assign fault_d = |(unit_access & ~unit_clk_en);

    // Read mux; unmapped addresses read zero and flag an error.
    always_comb begin
        rdata_d = 32'h0000_0000;
        if (hit_cfg) begin
            rdata_d = cfg_q;
        end else if (hit_run) begin
            rdata_d = run_gate;
        end else if (hit_sleep) begin
            rdata_d = sleep_gate;
        end else if (hit_deep) begin
            rdata_d = deep_gate;
        end else if (hit_mode) begin
            rdata_d = {29'h0000_0000, auto_gating, power_mode};
        end
    end
    assign err_d = (reg_rd | reg_wr) & ~hit_any;

    // Read data stands in the cycle after the strobe only.
    always_ff @(posedge clk) begin
        if (!rstn) begin
            cfg_q <= LPCG_CFG_RESET;
            rdata_q <= 32'h0000_0000;
            err_q <= 1'b0;
            fault_q <= 1'b0;
        end else begin
            cfg_q <= cfg_d;
            rdata_q <= reg_rd ? rdata_d : 32'h0000_0000;
            err_q <= err_d;
            fault_q <= fault_d;
        end
    end

    assign reg_rdata = rdata_q;
    assign reg_err = err_q;
    assign unit_bus_fault = fault_q;
endmodule // lpcg_top
`default_nettype wire
